/* File: hw/nfc_host.sv */
// host-side nand flash controller: drives the strobe pins of one large-page part
// assumes a 20 MHz clock, pins registered here, ready/busy arriving asynchronously
//
// Function
// - scan spare marker in pages zero, one
// - never erase or program marked blocks
// - status failure retires the block
// - compute error-correction syndrome on reads
// - single-bit read errors never retire blocks
// - replacement copying of earlier pages, same positions, left to the command source
// - failed page data rewrite into replacement left to the command source
// - failed block recorded, never erased or programmed again
// - program pages only in ascending order
// - chip select released while load stalls
// - x8 address: five cycles, fixed split
// - x16 address: five cycles, narrower column
// - x16 upper lines zero on command/address
// - id read starts with its command
`timescale 1ns/10ps
module nfc_host #(
  parameter bit X16 = 1'b0,
  parameter int NBLK = 2048,
  parameter int FIFO_D = 4,
  localparam int DW = X16 ? 16 : 8
)(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // command port
  input wire logic i_cmd_valid,
  input wire nfc_pkg::nfc_cmd_s i_cmd,
  output logic o_cmd_ready,
  // program data
  input wire logic i_wr_valid,
  input wire logic [DW-1:0] i_wr_data,
  output logic o_wr_ready,
  // read data and results
  output logic o_rd_valid,
  output logic [DW-1:0] o_rd_data,
  output logic o_done,
  output logic o_fail,
  output logic o_refused,
  output logic [DW-1:0] o_id_dev,
  output logic [DW-1:0] o_id_cfg,
  output logic [DW-1:0] o_ecc_par,
  output logic [nfc_pkg::COL_W-1:0] o_ecc_idx,
  // flash pins
  output nfc_pkg::nfc_pin_s o_pin,
  output logic [DW-1:0] o_io_out,
  output logic o_io_oe,
  input wire logic [DW-1:0] i_io_in,
  input wire logic i_rb_n
);
  typedef enum logic [3:0] {
    S_IDLE, S_CMD1, S_ADDR, S_DIN, S_CMD2, S_BUSY, S_DOUT, S_GAP
  } nfc_st_e;

  // busy shows through the ready/busy synchroniser only after four edges, so the
  // wait after a confirm covers them, or a stale ready would end the busy wait early
  localparam int RB_SYNC_CYC = 3;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  nfc_st_e st_ff, nxt_st, ret_ff, nxt_ret;
  nfc_pkg::nfc_cmd_s cmd_ff;
  nfc_pkg::nfc_pin_s pin_ff, nxt_pin;
  logic ph_ff, nxt_ph;
  logic stat_ff, nxt_stat;
  logic scan_pg_ff, nxt_scan;
  logic [nfc_pkg::COL_W-1:0] cnt_ff, nxt_cnt;
  logic [2:0] gap_ff, nxt_gap;
  logic [DW-1:0] io_out_ff, nxt_io;
  logic io_oe_ff;
  logic rb1_ff, rb2_ff, rb3_ff, rb_hi_ff;
  logic [NBLK-1:0] bad_ff;
  logic [nfc_pkg::BLK_W-1:0] pblk_ff;
  logic [nfc_pkg::PG_W:0] pnext_ff;
  logic rd_valid_ff, done_ff, fail_ff, refused_ff;
  logic [DW-1:0] rd_data_ff, id_dev_ff, id_cfg_ff, ecc_par_ff;
  logic [nfc_pkg::COL_W-1:0] ecc_idx_ff;
  logic fifo_valid;
  logic [DW-1:0] fifo_data;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire op_read = cmd_ff.op == nfc_pkg::NFC_OP_READ;
  wire op_prog = cmd_ff.op == nfc_pkg::NFC_OP_PROG;
  wire op_erase = cmd_ff.op == nfc_pkg::NFC_OP_ERASE;
  wire op_id = cmd_ff.op == nfc_pkg::NFC_OP_ID;
  wire op_scan = cmd_ff.op == nfc_pkg::NFC_OP_SCAN;
  wire [nfc_pkg::COL_W-1:0] page_max = X16 ? nfc_pkg::PAGE_LEN_X16 : nfc_pkg::PAGE_LEN_X8;
  wire [nfc_pkg::COL_W-1:0] spare_col = X16 ? nfc_pkg::SPARE_COL_X16 : nfc_pkg::SPARE_COL_X8;

  // request screening; the bad table lives only here, so a marker lost from the
  // part is needed again after reset, which clears this table
  wire in_wr = (i_cmd.op == nfc_pkg::NFC_OP_PROG) || (i_cmd.op == nfc_pkg::NFC_OP_ERASE);
  wire in_len = (i_cmd.op == nfc_pkg::NFC_OP_PROG) || (i_cmd.op == nfc_pkg::NFC_OP_READ);
  wire in_bad = in_wr && bad_ff[i_cmd.blk];
  wire same_blk = i_cmd.blk == pblk_ff;
  wire order_ok = same_blk ? ({1'b0, i_cmd.page} >= pnext_ff) : (i_cmd.page == '0);
  wire in_order = (i_cmd.op != nfc_pkg::NFC_OP_PROG) || order_ok;
  wire len_ok = !in_len || ((i_cmd.len != '0) && (i_cmd.len <= page_max));
  wire refuse = in_bad || !in_order || !len_ok;
  wire take = (st_ff == S_IDLE) && i_cmd_valid;

  // address bytes, column first then row, low part first
  wire [nfc_pkg::COL_W-1:0] eff_col = op_scan ? spare_col : cmd_ff.col;
  wire [nfc_pkg::PG_W-1:0] eff_pg = op_scan ? nfc_pkg::PG_W'(scan_pg_ff) : cmd_ff.page;
  wire [nfc_pkg::BLK_W+nfc_pkg::PG_W-1:0] row = {cmd_ff.blk, eff_pg};
  wire [7:0] col_hi = X16 ? {5'h00, eff_col[10:8]} : {4'h0, eff_col[11:8]};
  wire [2:0] adr_n = op_erase ? nfc_pkg::ADDR_CYC_ROW : (op_id ? nfc_pkg::ADDR_CYC_ID : nfc_pkg::ADDR_CYC_FULL);
  wire [2:0] adr_idx = cnt_ff[2:0] + (op_erase ? nfc_pkg::ROW_FIRST_IDX : 3'h0);
  wire [7:0] adr_byte = op_id ? nfc_pkg::ID_ADDR :
                        (adr_idx == 3'h0) ? eff_col[7:0] :
                        (adr_idx == 3'h1) ? col_hi :
                        (adr_idx == 3'h2) ? row[7:0] :
                        (adr_idx == 3'h3) ? row[15:8] : {7'h00, row[16]};
  wire [7:0] cmd1_byte = stat_ff ? nfc_pkg::CMD_STATUS :
                         op_prog ? nfc_pkg::CMD_PROG1 :
                         op_erase ? nfc_pkg::CMD_ERASE1 :
                         op_id ? nfc_pkg::CMD_ID : nfc_pkg::CMD_READ1;
  wire [7:0] cmd2_byte = op_prog ? nfc_pkg::CMD_PROG2 : (op_erase ? nfc_pkg::CMD_ERASE2 : nfc_pkg::CMD_READ2);
  wire [7:0] ctl_byte = (st_ff == S_ADDR) ? adr_byte : ((st_ff == S_CMD2) ? cmd2_byte : cmd1_byte);

  // read side: the strobe spacing guarantees the data, so the bus is sampled
  // raw at the rising edge of the read strobe rather than through a synchroniser
  wire cap = (st_ff == S_DOUT) && ph_ff;
  wire [DW-1:0] rd_word = i_io_in;
  wire [nfc_pkg::COL_W-1:0] out_len = (stat_ff || op_scan) ? 12'h001 : (op_id ? nfc_pkg::ID_LEN : cmd_ff.len);
  wire last_out = cnt_ff == out_len - 1'b1;
  wire last_in = cnt_ff == cmd_ff.len - 1'b1;
  wire stat_fail = stat_ff && rd_word[nfc_pkg::ST_FAIL_BIT];
  wire scan_bad = op_scan && !stat_ff && !(&rd_word);
  wire mark_bad = cap && (stat_fail || scan_bad);
  wire scan_next = op_scan && !stat_ff && !scan_bad && !scan_pg_ff;
  wire din_go = (st_ff == S_DIN) && !ph_ff && fifo_valid;
  wire fifo_take = din_go;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_ph = ph_ff;
    nxt_cnt = cnt_ff;
    nxt_gap = gap_ff;
    nxt_ret = ret_ff;
    nxt_stat = stat_ff;
    nxt_scan = scan_pg_ff;
    unique case (st_ff)
      S_IDLE: begin
        if (take && !refuse) begin
          nxt_st = S_CMD1;
          nxt_ph = 1'b0;
          nxt_cnt = '0;
          nxt_stat = 1'b0;
          nxt_scan = 1'b0;
        end
      end
      S_CMD1: begin
        nxt_ph = ~ph_ff;
        if (ph_ff && stat_ff) begin
          nxt_st = S_GAP;
          nxt_gap = 3'(nfc_pkg::WHR_CYC);
          nxt_ret = S_DOUT;
        end else if (ph_ff) begin
          nxt_st = S_ADDR;
        end
      end
      S_ADDR: begin
        nxt_ph = ~ph_ff;
        if (ph_ff && (cnt_ff[2:0] == adr_n - 1'b1)) begin
          nxt_cnt = '0;
          if (op_prog) begin
            nxt_st = S_GAP;
            nxt_gap = 3'(nfc_pkg::ADL_CYC);
            nxt_ret = S_DIN;
          end else if (op_id) begin
            nxt_st = S_GAP;
            nxt_gap = 3'(nfc_pkg::WHR_CYC);
            nxt_ret = S_DOUT;
          end else begin
            nxt_st = S_CMD2;
          end
        end else if (ph_ff) begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      S_DIN: begin
        // a missing word holds phase 0 with chip select released
        if (ph_ff || fifo_valid) begin
          nxt_ph = ~ph_ff;
        end
        if (ph_ff && last_in) begin
          nxt_cnt = '0;
          nxt_st = S_CMD2;
        end else if (ph_ff) begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      S_CMD2: begin
        nxt_ph = ~ph_ff;
        if (ph_ff) begin
          nxt_st = S_GAP;
          nxt_gap = 3'(nfc_pkg::WB_CYC + RB_SYNC_CYC);
          nxt_ret = S_BUSY;
        end
      end
      S_BUSY: begin
        if (rb_hi_ff && (op_prog || op_erase)) begin
          nxt_st = S_CMD1;
          nxt_stat = 1'b1;
        end else if (rb_hi_ff) begin
          nxt_st = S_GAP;
          nxt_gap = 3'(nfc_pkg::RR_CYC);
          nxt_ret = S_DOUT;
        end
      end
      S_DOUT: begin
        nxt_ph = ~ph_ff;
        if (ph_ff && last_out && scan_next) begin
          // the next page's command strobe keeps the read-to-write distance
          nxt_scan = 1'b1;
          nxt_cnt = '0;
          nxt_st = S_GAP;
          nxt_gap = 3'(nfc_pkg::RHW_CYC);
          nxt_ret = S_CMD1;
        end else if (ph_ff && last_out) begin
          nxt_st = S_GAP;
          nxt_gap = 3'(nfc_pkg::RHW_CYC);
          nxt_ret = S_IDLE;
        end else if (ph_ff) begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      S_GAP: begin
        if (gap_ff == '0) begin
          nxt_st = ret_ff;
        end else begin
          nxt_gap = gap_ff - 1'b1;
        end
      end
    endcase
  end

  // pin values for the next cycle: every strobe comes from a flip-flop
  always_comb begin
    nxt_pin.cle = ((st_ff == S_CMD1) || (st_ff == S_CMD2));
    nxt_pin.ale = (st_ff == S_ADDR);
    nxt_pin.ce_n = (st_ff == S_IDLE) || ((st_ff == S_DIN) && !ph_ff && !fifo_valid);
    nxt_pin.we_n = !(!ph_ff && (nxt_pin.cle || nxt_pin.ale || din_go));
    nxt_pin.output_strobe_low = !((st_ff == S_DOUT) && !ph_ff);
    nxt_io = io_out_ff;
    if (nxt_pin.cle || nxt_pin.ale) begin
      nxt_io = DW'(ctl_byte);
    end else if (din_go) begin
      nxt_io = fifo_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      st_ff <= S_IDLE;
      ret_ff <= S_IDLE;
      ph_ff <= 1'b0;
      cnt_ff <= '0;
      gap_ff <= '0;
      stat_ff <= 1'b0;
      scan_pg_ff <= 1'b0;
      cmd_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      ret_ff <= nxt_ret;
      ph_ff <= nxt_ph;
      cnt_ff <= nxt_cnt;
      gap_ff <= nxt_gap;
      stat_ff <= nxt_stat;
      scan_pg_ff <= nxt_scan;
      if (take) begin
        cmd_ff <= i_cmd;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pin_ff <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1, output_strobe_low: 1'b1};
      io_out_ff <= '0;
      io_oe_ff <= 1'b0;
    end else begin
      pin_ff <= nxt_pin;
      io_out_ff <= nxt_io;
      io_oe_ff <= (st_ff == S_CMD1) || (st_ff == S_CMD2) || (st_ff == S_ADDR) || (st_ff == S_DIN);
    end
  end

  // ----------------------------------------------------------------
  // ready/busy synchroniser: second and third stage must agree
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rb1_ff <= 1'b0;
      rb2_ff <= 1'b0;
      rb3_ff <= 1'b0;
      rb_hi_ff <= 1'b0;
    end else begin
      rb1_ff <= i_rb_n;
      rb2_ff <= rb1_ff;
      rb3_ff <= rb2_ff;
      if (rb2_ff == rb3_ff) begin
        rb_hi_ff <= rb3_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // invalid-block table and page order tracking
  // ----------------------------------------------------------------
  // a failing block is only recorded; copying its earlier pages and the
  // buffered failing page into a spare block is left to the command source,
  // which issues reads and programs of the same page numbers
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      bad_ff <= '0;
      pblk_ff <= '0;
      pnext_ff <= '0;
    end else begin
      if (mark_bad) begin
        bad_ff[cmd_ff.blk] <= 1'b1;
      end
      if (take && !refuse && (i_cmd.op == nfc_pkg::NFC_OP_PROG)) begin
        pblk_ff <= i_cmd.blk;
        pnext_ff <= {1'b0, i_cmd.page} + 1'b1;
      end else if (take && !refuse && (i_cmd.op == nfc_pkg::NFC_OP_ERASE) && same_blk) begin
        pnext_ff <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // results, id capture and read syndrome
  // ----------------------------------------------------------------
  // read errors only update the syndrome; a block is never retired for them
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rd_valid_ff <= 1'b0;
      rd_data_ff <= '0;
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
      refused_ff <= 1'b0;
      id_dev_ff <= '0;
      id_cfg_ff <= '0;
      ecc_par_ff <= '0;
      ecc_idx_ff <= '0;
    end else begin
      rd_valid_ff <= cap && !stat_ff && (op_read || op_id);
      done_ff <= (st_ff == S_GAP) && (gap_ff == '0) && (ret_ff == S_IDLE);
      refused_ff <= take && refuse;
      if (take && !refuse) begin
        fail_ff <= 1'b0;
        ecc_par_ff <= '0;
        ecc_idx_ff <= '0;
      end else if (cap && (stat_ff || op_scan)) begin
        fail_ff <= stat_fail || scan_bad;
      end
      if (cap) begin
        rd_data_ff <= rd_word;
      end
      if (cap && op_id && (cnt_ff == nfc_pkg::ID_DEV_IDX)) begin
        id_dev_ff <= rd_word;
      end
      if (cap && op_id && (cnt_ff == nfc_pkg::ID_CFG_IDX)) begin
        id_cfg_ff <= rd_word;
      end
      if (cap && op_read) begin
        ecc_par_ff <= ecc_par_ff ^ rd_word;
        ecc_idx_ff <= (^rd_word) ? (ecc_idx_ff ^ cnt_ff) : ecc_idx_ff;
      end
    end
  end

  nfc_fifo #(.W(DW), .D(FIFO_D)) u_fifo (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_valid(i_wr_valid),
    .i_data(i_wr_data),
    .o_ready(o_wr_ready),
    .o_valid(fifo_valid),
    .o_data(fifo_data),
    .i_ready(fifo_take)
  );

  assign o_cmd_ready = (st_ff == S_IDLE);
  assign o_rd_valid = rd_valid_ff;
  assign o_rd_data = rd_data_ff;
  assign o_done = done_ff;
  assign o_fail = fail_ff;
  assign o_refused = refused_ff;
  assign o_id_dev = id_dev_ff;
  assign o_id_cfg = id_cfg_ff;
  assign o_ecc_par = ecc_par_ff;
  assign o_ecc_idx = ecc_idx_ff;
  assign o_pin = pin_ff;
  assign o_io_out = io_out_ff;
  assign o_io_oe = io_oe_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_take_read;
    take && !refuse && (i_cmd.op == nfc_pkg::NFC_OP_READ);
  endsequence
  sequence s_first_addr;
    pin_ff.ale && !pin_ff.we_n && (io_out_ff[7:0] == $past(i_cmd.col[7:0], 4));
  endsequence

  property p_upper_zero;
    (pin_ff.cle || pin_ff.ale) |-> ((io_out_ff >> 8) == '0);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper lines not zero");

  property p_no_bad_write;
    (st_ff == S_CMD1) && !stat_ff && (op_erase || op_prog) |-> !bad_ff[cmd_ff.blk];
  endproperty
  a_no_bad_write: assert property (p_no_bad_write) else $error("bad block written");

  property p_fail_retire;
    cap && stat_ff && rd_word[nfc_pkg::ST_FAIL_BIT] |=> bad_ff[cmd_ff.blk] && fail_ff;
  endproperty
  a_fail_retire: assert property (p_fail_retire) else $error("failed block kept");

  property p_pass_clean;
    cap && stat_ff && !rd_word[nfc_pkg::ST_FAIL_BIT] |=> !fail_ff ##[1:8] done_ff;
  endproperty
  a_pass_clean: assert property (p_pass_clean) else $error("pass status mishandled");

  property p_order;
    take && (i_cmd.op == nfc_pkg::NFC_OP_PROG) && same_blk && ({1'b0, i_cmd.page} < pnext_ff) |=> refused_ff;
  endproperty
  a_order: assert property (p_order) else $error("page order broken");

  property p_ce_release;
    (st_ff == S_DIN) && !ph_ff && !fifo_valid |=> pin_ff.ce_n && pin_ff.we_n;
  endproperty
  a_ce_release: assert property (p_ce_release) else $error("chip select held");

  property p_id_cmd;
    take && !refuse && (i_cmd.op == nfc_pkg::NFC_OP_ID) |=> ##1 (pin_ff.cle && !pin_ff.we_n
      && (io_out_ff[7:0] == nfc_pkg::CMD_ID)) ##2 (pin_ff.ale && (io_out_ff[7:0] == nfc_pkg::ID_ADDR));
  endproperty
  a_id_cmd: assert property (p_id_cmd) else $error("id command wrong");

  property p_addr_order;
    s_take_read |=> ##3 s_first_addr ##2 (pin_ff.ale && !pin_ff.we_n) ##2 (pin_ff.ale && !pin_ff.we_n)
      ##2 (pin_ff.ale && !pin_ff.we_n) ##2 (pin_ff.ale && !pin_ff.we_n) ##1 (pin_ff.ale && pin_ff.we_n)
      ##1 pin_ff.cle;
  endproperty
  a_addr_order: assert property (p_addr_order) else $error("address cycles wrong");
endmodule

/* File: hw/nfc_pkg.sv */
// constants and carrier types shared by the nand host controller, the flash model and the bench
// assumes a 20 MHz controller clock and a large-page nand part, x8 or x16
package nfc_pkg;

  // ----------------------------------------------------------------
  // clock and pin timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 50;
  localparam int T_WB_NS = 100;
  localparam int T_ADDRESS_TO_DATA_GAP_NS = 100;
  localparam int T_WHR_NS = 60;
  localparam int T_RR_NS = 20;
  localparam int T_RHW_NS = 100;
  // least times: round up, never below one cycle
  localparam int WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADL_CYC = (T_ADDRESS_TO_DATA_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WHR_CYC = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
  localparam int RR_CYC = (T_RR_NS + CLK_NS - 1) / CLK_NS;
  localparam int RHW_CYC = (T_RHW_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // command bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ1 = 8'h00;
  localparam logic [7:0] CMD_READ2 = 8'h30;
  localparam logic [7:0] CMD_PROG1 = 8'h80;
  localparam logic [7:0] CMD_PROG2 = 8'h10;
  localparam logic [7:0] CMD_ERASE1 = 8'h60;
  localparam logic [7:0] CMD_ERASE2 = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] ID_ADDR = 8'h00;

  // ----------------------------------------------------------------
  // geometry and field positions
  // ----------------------------------------------------------------
  localparam int PG_W = 6;
  localparam int BLK_W = 11;
  localparam int COL_W = 12;
  localparam logic [COL_W-1:0] PAGE_LEN_X8 = 12'h840;
  localparam logic [COL_W-1:0] PAGE_LEN_X16 = 12'h420;
  localparam logic [COL_W-1:0] SPARE_COL_X8 = 12'h800;
  localparam logic [COL_W-1:0] SPARE_COL_X16 = 12'h400;
  localparam logic [2:0] ADDR_CYC_FULL = 3'h5;
  localparam logic [2:0] ADDR_CYC_ROW = 3'h3;
  localparam logic [2:0] ADDR_CYC_ID = 3'h1;
  localparam logic [2:0] ROW_FIRST_IDX = 3'h2;
  localparam logic [COL_W-1:0] ID_LEN = 12'h004;
  localparam logic [COL_W-1:0] ID_DEV_IDX = 12'h001;
  localparam logic [COL_W-1:0] ID_CFG_IDX = 12'h003;
  localparam int ST_FAIL_BIT = 0;

  typedef enum logic [2:0] {
    NFC_OP_READ,
    NFC_OP_PROG,
    NFC_OP_ERASE,
    NFC_OP_ID,
    NFC_OP_SCAN
  } nfc_op_e;

  typedef struct packed {
    nfc_op_e op;
    logic [BLK_W-1:0] blk;
    logic [PG_W-1:0] page;
    logic [COL_W-1:0] col;
    logic [COL_W-1:0] len;
  } nfc_cmd_s;

  // output_strobe_low is the active-low read strobe
  typedef struct packed {
    logic cle;
    logic ale;
    logic ce_n;
    logic we_n;
    logic output_strobe_low;
  } nfc_pin_s;

endpackage

/* File: hw/nfc_fifo.sv */
// small first-in first-out buffer for the program data path
// assumes one clock, synchronous active-low reset, valid/ready on both sides
`timescale 1ns/10ps
module nfc_fifo #(
  parameter int W = 16,
  parameter int D = 4
)(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // fill side
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  // drain side
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0] mem [D];
  logic [AW-1:0] wptr_ff;
  logic [AW-1:0] rptr_ff;
  logic [AW:0] cnt_ff;

  wire push = i_valid && o_ready;
  wire pop = o_valid && i_ready;

  assign o_ready = (cnt_ff != (AW+1)'(D));
  assign o_valid = (cnt_ff != '0);
  assign o_data = mem[rptr_ff];

  // ----------------------------------------------------------------
  // pointers and storage
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wptr_ff <= (wptr_ff == AW'(D - 1)) ? '0 : wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= (rptr_ff == AW'(D - 1)) ? '0 : rptr_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wptr_ff] <= i_data;
    end
  end
endmodule

/* File: tb/nfc_flash_model.sv */
// behavioural x8 large-page part answering the host strobes
// assumes strobes from nfc_host; busy shortened to 2 us to keep runs short
`timescale 1ns/10ps
module nfc_flash_model #(
  parameter logic [7:0] MAKER = 8'hA1, // arbitrary value
  parameter logic [7:0] DEV = 8'hB2, // arbitrary value
  parameter logic [7:0] CFG = 8'hC3 // arbitrary value
)(
  // strobes and data
  input wire nfc_pkg::nfc_pin_s i_pin,
  input wire logic [7:0] i_io,
  input wire logic i_fail,
  // answers
  output logic [7:0] o_io,
  output logic o_rb_n
);
  logic [7:0] cmd;
  logic [7:0] pf;
  logic [7:0] adr [5];
  logic [7:0] mem [int];
  int na;
  int k;
  function automatic int loc();
    return {adr[4][0], adr[3], adr[2], adr[1][3:0], adr[0]} + k;
  endfunction
  initial begin
    o_rb_n = 1'b1;
    o_io = 8'h5A;
    pf = 8'hE0;
    na = 0;
    mem[{17'h000C0, 12'h800}] = 8'h00;
  end
  always @(posedge i_pin.we_n) if (!i_pin.ce_n) begin
    if (i_pin.cle) begin
      cmd = i_io;
      na = 0;
      k = 0;
      if (cmd == 8'h10 || cmd == 8'hD0) pf = {7'h70, i_fail};
      if (cmd == 8'h10 || cmd == 8'h30 || cmd == 8'hD0) begin
        o_rb_n = 1'b0;
        #2000 o_rb_n = 1'b1;
      end
    end else if (i_pin.ale) begin
      if (na < 5) adr[na] = i_io;
      na++;
    end else begin
      mem[loc()] = i_io;
      k++;
    end
  end
  always @(negedge i_pin.output_strobe_low) begin
    case (cmd)
      8'h90: o_io = k == 0 ? MAKER : k == 1 ? DEV : k == 3 ? CFG : 8'h00;
      8'h70: o_io = pf;
      default: o_io = mem.exists(loc()) ? mem[loc()] : 8'hFF;
    endcase
    k++;
  end
  // output hold runs out: never leave a stale value on the bus
  always @(posedge i_pin.output_strobe_low) #20 o_io = ~o_io;
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for nfc_host in x8 form against the flash model
// assumes a 50 ns clock and inputs driven 1 ns after each rising edge
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] DEV = 8'h6D; // arbitrary value
  localparam logic [7:0] CFG = 8'h2B; // arbitrary value
  logic i_clk, i_resetn, cv, cr, wv, wr, rv, done, fl, rf, oe, rb, fail_in, got_ref;
  logic [7:0] wd, rd, io_out, fio, iid, icfg, ep, par;
  logic [11:0] ei, idx;
  nfc_pkg::nfc_cmd_s cmd;
  nfc_pkg::nfc_pin_s pin;
  int miscompares = 0;
  int check_count = 0;
  int seed = 32'h2effc58c;
  logic [7:0] expq[$];
  logic [7:0] rdq[$];
  nfc_host u_dut(.i_clk(i_clk), .i_resetn(i_resetn), .i_cmd_valid(cv), .i_cmd(cmd), .o_cmd_ready(cr),
    .i_wr_valid(wv), .i_wr_data(wd), .o_wr_ready(wr), .o_rd_valid(rv), .o_rd_data(rd), .o_done(done),
    .o_fail(fl), .o_refused(rf), .o_id_dev(iid), .o_id_cfg(icfg), .o_ecc_par(ep), .o_ecc_idx(ei),
    .o_pin(pin), .o_io_out(io_out), .o_io_oe(oe), .i_io_in(oe ? io_out : fio), .i_rb_n(rb));
  nfc_flash_model #(.DEV(DEV), .CFG(CFG)) u_flash(.i_pin(pin), .i_io(io_out), .i_fail(fail_in),
    .o_io(fio), .o_rb_n(rb));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) if (rv === 1'b1) rdq.push_back(rd);
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic run(input nfc_pkg::nfc_op_e op, input int b, input int p, input int c, input int l);
    int n;
    n = 0;
    rdq.delete();
    cmd = '{op, b[10:0], p[5:0], c[11:0], l[11:0]};
    cv = 1'b1;
    @(posedge i_clk);
    #1 cv = 1'b0;
    while (done !== 1'b1 && rf !== 1'b1 && n < 4000) begin
      @(posedge i_clk);
      #1 n++;
    end
    got_ref = rf;
    if (n >= 4000) miscompares++;
  endtask
  // the fifo refuses once four words wait; the word is held until taken
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      wv = 1'b1;
      wd = 8'($random(seed));
      expq.push_back(wd);
      while (wr !== 1'b1) begin
        @(posedge i_clk);
        #1;
      end
      @(posedge i_clk);
      #1;
    end
    wv = 1'b0;
  endtask
  initial begin
    i_resetn = 1'b0; cv = 1'b0; wv = 1'b0; wd = 8'h00; fail_in = 1'b0; cmd = '0;
    repeat (8) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    run(nfc_pkg::NFC_OP_ID, 0, 0, 0, 0);
    check(iid, DEV);
    check(icfg, CFG);
    check(rdq.size(), 4);
    check(cr, 1);
    $display("test id done");
    run(nfc_pkg::NFC_OP_SCAN, 3, 0, 0, 0);
    check(fl, 1);
    run(nfc_pkg::NFC_OP_SCAN, 0, 0, 0, 0);
    check(fl, 0);
    run(nfc_pkg::NFC_OP_PROG, 3, 0, 0, 1);
    check(got_ref, 1);
    run(nfc_pkg::NFC_OP_ERASE, 3, 0, 0, 0);
    check(got_ref, 1);
    $display("test scan done");
    // data arrives late, so the load starts with chip select released
    fork
      begin
        repeat (20) @(posedge i_clk);
        #1 push(6);
      end
      run(nfc_pkg::NFC_OP_PROG, 1, 0, 0, 6);
    join
    check(fl, 0);
    run(nfc_pkg::NFC_OP_READ, 1, 0, 0, 6);
    check(rdq.size(), 6);
    for (int i = 0; i < 6; i++) check(rdq[i], expq[i]);
    par = 8'h00;
    idx = 12'h000;
    for (int i = 0; i < 6; i++) begin
      par = par ^ expq[i];
      if (^expq[i]) idx = idx ^ 12'(i);
    end
    check({ei, ep}, {idx, par});
    run(nfc_pkg::NFC_OP_PROG, 1, 0, 0, 1);
    check(got_ref, 1);
    run(nfc_pkg::NFC_OP_READ, 1, 0, 0, 0);
    check(got_ref, 1);
    run(nfc_pkg::NFC_OP_READ, 1, 0, 0, 2113);
    check(got_ref, 1);
    $display("test program done");
    run(nfc_pkg::NFC_OP_READ, 1029, 9, 291, 1);
    check({u_flash.adr[0], u_flash.adr[1], u_flash.adr[2], u_flash.adr[3], u_flash.adr[4]}, 40'h2301490101);
    check(rdq[0], 8'hFF);
    $display("test address done");
    fail_in = 1'b1;
    push(1);
    run(nfc_pkg::NFC_OP_PROG, 2, 0, 0, 1);
    check(fl, 1);
    fail_in = 1'b0;
    run(nfc_pkg::NFC_OP_PROG, 2, 0, 0, 1);
    check(got_ref, 1);
    run(nfc_pkg::NFC_OP_ERASE, 2, 0, 0, 0);
    check(got_ref, 1);
    // the failed word, still buffered here, goes to the same page of a spare block
    wv = 1'b1;
    wd = expq[6];
    @(posedge i_clk);
    #1 wv = 1'b0;
    run(nfc_pkg::NFC_OP_PROG, 4, 0, 0, 1);
    run(nfc_pkg::NFC_OP_READ, 4, 0, 0, 1);
    check({fl, rdq[0]}, {1'b0, expq[6]});
    run(nfc_pkg::NFC_OP_ERASE, 1, 0, 0, 0);
    check({got_ref, fl}, 0);
    $display("test failure done");
    tally_and_finish();
  end
  // roughly seventy-five times the expected run of about 40 us
  initial begin
    #3000000;
    miscompares++;
    tally_and_finish();
  end
endmodule
